// File: rtl/mbd_map.svh
`ifndef MBD_MAP_SVH
`define MBD_MAP_SVH
// sizes
`define MBD_NCH 8
`define MBD_NADC 4
`define MBD_SW 16
`define MBD_TW 32
`define MBD_CW 18
`define MBD_OW 24
`define MBD_AW 48
`define MBD_DW 14
// decimation limits and step masks
`define MBD_DEC_MIN 14'h0010
`define MBD_DEC_MAX 14'h2000
`define MBD_DEC_KNEE 14'h0400
`define MBD_DEC_RST 14'h0010
`define MBD_SH_RST 6'h04
`define MBD_MSK_LO 14'h0007
`define MBD_MSK_HI 14'h003F
`define MBD_SEG_LAST 3'h7
`define MBD_OSH 6'h09
// source select and test ramp
`define MBD_SRC_TEST 3'h4
`define MBD_TST_STEP 16'h0101
// default coefficient window, one per segment
`define MBD_COEF_DFLT {18'h04000, 18'h0C000, 18'h18000, 18'h1F000, \
	18'h1F000, 18'h18000, 18'h0C000, 18'h04000}
// quarter-wave sine, half-step offset
`define MBD_SIN_TAB {16'h7F62, 16'h7A7D, 16'h70E2, 16'h62F2, \
	16'h5134, 16'h3C57, 16'h2528, 16'h0C8C}
`endif

// File: rtl/mbd_pkg.sv
`include "mbd_map.svh"
package mbd_pkg;
	typedef enum logic [1:0] {
		MBD_IDLE = 2'b01,
		MBD_SCAN = 2'b10
	} mbd_ilv_t;

	typedef struct packed {
		logic        [`MBD_TW-1:0] pacc;
		logic signed [`MBD_SW-1:0] mi;
		logic signed [`MBD_SW-1:0] mq;
		logic signed [`MBD_AW-1:0] ai;
		logic signed [`MBD_AW-1:0] aq;
		logic signed [`MBD_OW-1:0] oi;
		logic signed [`MBD_OW-1:0] oq;
	} mbd_chan_st_t;

	typedef struct packed {
		logic signed [`MBD_SW-1:0]             smp;
		logic        [`MBD_SW-1:0]             tst;
		logic        [`MBD_DW-1:0]             dec;
		logic        [`MBD_DW-1:0]             pend;
		logic                                  pend_v;
		logic        [5:0]                     sh;
		logic        [2:0]                     seg;
		logic        [10:0]                    segc;
		logic                                  dump;
		logic        [`MBD_NCH-1:0][`MBD_CW-1:0] coef;
		logic                                  dec_err;
		logic                                  ovr;
		mbd_ilv_t                              ilv;
		logic        [`MBD_NCH-1:0]            en;
		logic        [2:0]                     idx;
	} mbd_top_st_t;
endpackage

// File: rtl/mbd_chan.sv
`timescale 1ns/100ps
`include "mbd_map.svh"
module mbd_chan (
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	input  wire logic signed [`MBD_SW-1:0] smp_i,
	input  wire logic        [`MBD_TW-1:0] tune_i,
	input  wire logic        [`MBD_TW-1:0] phase_i,
	input  wire logic signed [`MBD_CW-1:0] coef_i,
	input  wire logic                     restart_i,
	input  wire logic                     dump_i,
	input  wire logic        [5:0]        shift_i,
	output logic signed      [`MBD_OW-1:0] i_o,
	output logic signed      [`MBD_OW-1:0] q_o
);
	mbd_pkg::mbd_chan_st_t q;
	mbd_pkg::mbd_chan_st_t d;
	logic        [`MBD_TW-1:0] lo_ph;
	logic signed [31:0]        mp_i;
	logic signed [31:0]        mp_q;
	logic signed [33:0]        wp_i;
	logic signed [33:0]        wp_q;
	logic signed [`MBD_AW-1:0] wi;
	logic signed [`MBD_AW-1:0] wq;

	// quarter table folded by symmetry, saves three quarters of the rom
	function automatic logic signed [15:0] mbd_sin(input logic [4:0] p);
		logic [7:0][15:0] tab;
		logic [2:0]       k;
		tab = `MBD_SIN_TAB;
		k = p[3] ? ~p[2:0] : p[2:0];
		return p[4] ? -$signed(tab[k]) : $signed(tab[k]);
	endfunction

	// oscillator, mixer and weighted integrate-and-dump
	always_comb
	begin
		d = q;
		lo_ph = q.pacc + phase_i;
		d.pacc = restart_i ? '0 : q.pacc + tune_i;
		mp_i = smp_i * mbd_sin(lo_ph[31:27] + 5'h08);
		mp_q = -(smp_i * mbd_sin(lo_ph[31:27]));
		d.mi = mp_i[30:15];
		d.mq = mp_q[30:15];
		wp_i = q.mi * coef_i;
		wp_q = q.mq * coef_i;
		wi = q.ai + `MBD_AW'(wp_i);
		wq = q.aq + `MBD_AW'(wp_q);
		d.ai = wi;
		d.aq = wq;
		if (restart_i)
		begin
			d.ai = '0;
			d.aq = '0;
		end
		else if (dump_i)
		begin
			d.oi = `MBD_OW'(wi >>> (shift_i + `MBD_OSH));
			d.oq = `MBD_OW'(wq >>> (shift_i + `MBD_OSH));
			d.ai = '0;
			d.aq = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '0;
		else
			q <= d;
	end

	assign i_o = q.oi;
	assign q_o = q.oq;

	a_phase_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!restart_i |=> q.pacc == $past(q.pacc) + $past(tune_i))
		else $error("phase accumulator did not step by tuning word");
endmodule

// File: rtl/mbd_buf2.sv
`timescale 1ns/100ps
module mbd_buf2 #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	typedef struct packed {
		logic         v0;
		logic         v1;
		logic [W-1:0] e0;
		logic [W-1:0] e1;
	} mbd_buf_st_t;
	mbd_buf_st_t q;
	mbd_buf_st_t d;
	logic        pop;
	logic        push;

	// head always sits in e0 so the output is a plain flop
	always_comb
	begin
		d = q;
		pop = q.v0 && out_ready_i;
		push = in_valid_i && !q.v1;
		if (pop)
		begin
			d.e0 = q.e1;
			d.v0 = q.v1;
			d.v1 = 1'b0;
		end
		if (push)
		begin
			if (d.v0)
			begin
				d.e1 = in_data_i;
				d.v1 = 1'b1;
			end
			else
			begin
				d.e0 = in_data_i;
				d.v0 = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '0;
		else
			q <= d;
	end

	assign in_ready_o = !q.v1;
	assign out_valid_o = q.v0;
	assign out_data_o = q.e0;

	a_buf_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.v0 && !out_ready_i |=> q.v0 && $stable(q.e0))
		else $error("buffer head changed while stalled");
endmodule

// File: rtl/mbd_bank.sv
`timescale 1ns/100ps
`include "mbd_map.svh"
module mbd_bank (
	input  wire logic                                  clk_i,
	input  wire logic                                  rstn_i,
	input  wire logic [`MBD_NADC-1:0][`MBD_SW-1:0]     adc_i,
	input  wire logic [2:0]                            src_sel_i,
	input  wire logic [1:0]                            sync_i,
	input  wire logic [1:0]                            gate_i,
	input  wire logic                                  gate_bypass_i,
	input  wire logic [`MBD_DW-1:0]                    dec_i,
	input  wire logic                                  dec_load_i,
	input  wire logic [`MBD_NCH-1:0][`MBD_TW-1:0]      tune_i,
	input  wire logic [`MBD_NCH-1:0][`MBD_TW-1:0]      phase_i,
	input  wire logic [`MBD_NCH-1:0]                   ch_en_i,
	input  wire logic                                  coef_we_i,
	input  wire logic [2:0]                            coef_addr_i,
	input  wire logic [`MBD_CW-1:0]                    coef_data_i,
	input  wire logic                                  coef_dflt_i,
	input  wire logic                                  ovr_clr_i,
	output logic                                       out_valid_o,
	input  wire logic                                  out_ready_i,
	output logic      [2:0]                            out_ch_o,
	output logic      [`MBD_OW-1:0]                    out_i_o,
	output logic      [`MBD_OW-1:0]                    out_q_o,
	output logic      [`MBD_DW-1:0]                    dec_o,
	output logic                                       dec_err_o,
	output logic                                       ovr_o
);
	localparam int BW = 3 + 2 * `MBD_OW;

	mbd_pkg::mbd_top_st_t q;
	mbd_pkg::mbd_top_st_t d;
	logic [`MBD_NCH-1:0][`MBD_OW-1:0] ch_i;
	logic [`MBD_NCH-1:0][`MBD_OW-1:0] ch_q;
	logic [10:0]                      len_m1;
	logic                             dump_now;
	logic                             restart;
	logic                             gate_open;
	logic                             buf_valid;
	logic                             buf_ready;
	logic [BW-1:0]                    buf_data;
	logic                             adv;

	// decimation legality: 16..1024 by 8, above that up to 8192 by 64
	function automatic logic mbd_dec_ok(input logic [`MBD_DW-1:0] n);
		if (n < `MBD_DEC_MIN || n > `MBD_DEC_MAX)
			return 1'b0;
		if (n <= `MBD_DEC_KNEE)
			return (n & `MBD_MSK_LO) == '0;
		return (n & `MBD_MSK_HI) == '0;
	endfunction

	// output scale: ceiling log2 of the decimation factor
	function automatic logic [5:0] mbd_clog2(input logic [`MBD_DW-1:0] n);
		logic [5:0] s;
		s = '0;
		for (int i = 0; i < `MBD_DW; i++)
			if (n > (`MBD_DW'(1) << i))
				s = 6'(i + 1);
		return s;
	endfunction

	assign restart = |sync_i;
	assign gate_open = gate_bypass_i | (|gate_i);

	// filter period is eight coefficient segments of N/8 samples each
	assign len_m1 = q.dec[`MBD_DW-1:3] - 11'h001;
	assign dump_now = (q.seg == `MBD_SEG_LAST) && (q.segc == len_m1);

	// interleaver offer to the buffer
	assign buf_valid = (q.ilv == mbd_pkg::MBD_SCAN) && q.en[q.idx];
	assign buf_data = {q.idx, ch_i[q.idx], ch_q[q.idx]};
	assign adv = !q.en[q.idx] || buf_ready;

	// ***********************************************************
	// next state of the bank
	// ***********************************************************
	always_comb
	begin
		d = q;
		d.dump = dump_now && !restart;
		d.tst = q.tst + `MBD_TST_STEP;
		if (src_sel_i >= `MBD_SRC_TEST)
			d.smp = q.tst;
		else
			d.smp = adc_i[src_sel_i[1:0]];

		if (dec_load_i)
		begin
			if (mbd_dec_ok(dec_i))
			begin
				d.pend = dec_i;
				d.pend_v = 1'b1;
				d.dec_err = 1'b0;
			end
			else
				d.dec_err = 1'b1;
		end

		if (restart)
		begin
			d.seg = '0;
			d.segc = '0;
		end
		else if (q.segc == len_m1)
		begin
			d.segc = '0;
			d.seg = q.seg + 3'h1;
		end
		else
			d.segc = q.segc + 11'h001;

		// a new factor takes effect only on a period edge, so no
		// output sample mixes two bandwidths
		if ((dump_now || restart) && q.pend_v)
		begin
			d.dec = q.pend;
			d.sh = mbd_clog2(q.pend);
			d.pend_v = dec_load_i && mbd_dec_ok(dec_i);
		end

		if (coef_dflt_i)
			d.coef = `MBD_COEF_DFLT;
		else if (coef_we_i)
			d.coef[coef_addr_i] = coef_data_i;

		unique case (q.ilv)
			mbd_pkg::MBD_IDLE:
			begin
				if (q.dump && gate_open && (|ch_en_i))
				begin
					d.ilv = mbd_pkg::MBD_SCAN;
					d.en = ch_en_i;
					d.idx = '0;
				end
			end
			mbd_pkg::MBD_SCAN:
			begin
				if (adv)
				begin
					d.idx = q.idx + 3'h1;
					if (q.idx == `MBD_SEG_LAST)
						d.ilv = mbd_pkg::MBD_IDLE;
				end
			end
		endcase

		// stalled past the next period: samples are being overwritten
		if (ovr_clr_i)
			d.ovr = 1'b0;
		if (q.dump && q.ilv == mbd_pkg::MBD_SCAN)
			d.ovr = 1'b1;
	end

	// ***********************************************************
	// state register
	// ***********************************************************
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			q <= '0;
			q.dec <= `MBD_DEC_RST;
			q.sh <= `MBD_SH_RST;
			q.coef <= `MBD_COEF_DFLT;
			q.ilv <= mbd_pkg::MBD_IDLE;
		end
		else
			q <= d;
	end

	// ***********************************************************
	// channels
	// ***********************************************************
	// eight channels
	for (genvar c = 0; c < `MBD_NCH; c++)
	begin : g_ch
		mbd_chan u_chan (
			.clk_i     (clk_i),
			.rstn_i    (rstn_i),
			.smp_i     (q.smp),
			.tune_i    (tune_i[c]),
			.phase_i   (phase_i[c]),
			.coef_i    (q.coef[q.seg]),
			.restart_i (restart),
			.dump_i    (dump_now),
			.shift_i   (q.sh),
			.i_o       (ch_i[c]),
			.q_o       (ch_q[c])
		);
	end

	// ***********************************************************
	// output buffer
	// ***********************************************************
	// two entries ride out a one-cycle stall without dropping a word
	mbd_buf2 #(
		.W (BW)
	) u_buf (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (buf_valid),
		.in_ready_o  (buf_ready),
		.in_data_i   (buf_data),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i),
		.out_data_o  ({out_ch_o, out_i_o, out_q_o})
	);

	assign dec_o = q.dec;
	assign dec_err_o = q.dec_err;
	assign ovr_o = q.ovr;

	// ***********************************************************
	// checks
	// ***********************************************************
	sequence s_start;
		q.ilv == mbd_pkg::MBD_IDLE && q.dump && gate_open && (|ch_en_i);
	endsequence

	sequence s_scan0;
		q.ilv == mbd_pkg::MBD_SCAN && q.idx == 3'h0;
	endsequence

	a_src_test: assert property (@(posedge clk_i) disable iff (!rstn_i)
		src_sel_i >= `MBD_SRC_TEST |=> q.smp == $past(q.tst))
		else $error("test generator not selected");

	a_dec_legal: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mbd_dec_ok(q.dec))
		else $error("active decimation factor is illegal");

	a_dec_reject: assert property (@(posedge clk_i) disable iff (!rstn_i)
		dec_load_i && !mbd_dec_ok(dec_i) |=> q.dec_err && $stable(q.pend))
		else $error("illegal decimation factor was accepted");

	a_dump_space: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.dump |=> !q.dump [*8])
		else $error("output periods closer than minimum factor");

	a_coef_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
		coef_we_i && !coef_dflt_i |=> q.coef[$past(coef_addr_i)] == $past(coef_data_i))
		else $error("coefficient write lost");

	a_ilv_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_start |=> s_scan0)
		else $error("interleaver did not start on period edge");

	a_ilv_none: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.ilv == mbd_pkg::MBD_IDLE && ch_en_i == '0 |=> q.ilv == mbd_pkg::MBD_IDLE)
		else $error("interleaver ran with no channel enabled");

	a_ilv_order: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.ilv == mbd_pkg::MBD_SCAN && adv && q.idx != `MBD_SEG_LAST
		|=> q.ilv == mbd_pkg::MBD_SCAN && q.idx == $past(q.idx) + 3'h1)
		else $error("interleaver skipped or reordered a channel");

	a_ilv_mask: assert property (@(posedge clk_i) disable iff (!rstn_i)
		buf_valid && buf_ready |=> ##1 out_valid_o && q.en[out_ch_o] || !out_valid_o
		|| q.ilv == mbd_pkg::MBD_IDLE)
		else $error("disabled channel reached the output");

	// overrun check
	a_ovr_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.dump && q.ilv == mbd_pkg::MBD_SCAN |=> q.ovr)
		else $error("overrun not flagged");
endmodule

// File: tb/mbd_sink.sv
`timescale 1ns/100ps
module mbd_sink (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        stall_i,
	input  wire logic        valid_i,
	output logic             ready_o,
	input  wire logic [2:0]  ch_i,
	input  wire logic [23:0] i_i,
	input  wire logic [23:0] q_i
);
	// ****************************************
	// capture side of the output stream
	// ****************************************
	logic [2:0]  ch_q[$];
	logic [47:0] last_q [8];

	// ready moves just after an edge; a word counts only where both sides agree
	always @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ready_o <= 1'b0;
		else
		begin
			ready_o <= !stall_i;
			if (valid_i && ready_o)
			begin
				ch_q.push_back(ch_i);
				last_q[ch_i] <= {i_i, q_i};
			end
		end
	end
endmodule

// File: tb/test_mbd_bank.sv
`timescale 1ns/100ps
`include "mbd_map.svh"
module test_mbd_bank;
	// ****************************************
	// stimulus and design under test
	// ****************************************
	logic                              clk_i = 1'b0;
	logic                              rstn_i = 1'b0;
	logic [`MBD_NADC-1:0][`MBD_SW-1:0] adc_i = {16'h0000, 16'h4000, 16'h0000, 16'h0000};
	logic [2:0]                        src_sel_i = 3'h2;
	logic [1:0]                        sync_i = 2'h0;
	logic [1:0]                        gate_i = 2'h0;
	logic                              gate_bypass_i = 1'b1;
	logic [`MBD_DW-1:0]                dec_i = 14'h0010;
	logic                              dec_load_i = 1'b0;
	logic [`MBD_NCH-1:0][`MBD_TW-1:0]  tune_i = '0;
	logic [`MBD_NCH-1:0][`MBD_TW-1:0]  phase_i = '0;
	logic [`MBD_NCH-1:0]               ch_en_i = 8'h01;
	logic                              coef_we_i = 1'b0;
	logic [2:0]                        coef_addr_i = 3'h0;
	logic [`MBD_CW-1:0]                coef_data_i = 18'h00000;
	logic                              coef_dflt_i = 1'b0;
	logic                              ovr_clr_i = 1'b0;
	logic                              stall = 1'b0;
	logic                              out_valid_o;
	logic                              out_ready_i;
	logic                              dec_err_o;
	logic                              ovr_o;
	logic [2:0]                        out_ch_o;
	logic [`MBD_OW-1:0]                out_i_o;
	logic [`MBD_OW-1:0]                out_q_o;
	logic [`MBD_DW-1:0]                dec_o;
	int                                num_errors = 0;
	int                                cmp_count = 0;
	// decimation requests beside the error flag each should give
	localparam logic [14:0] dec_rows [10] = '{{14'h0010, 1'b0}, {14'h0008, 1'b1},
		{14'h0014, 1'b1}, {14'h0018, 1'b0}, {14'h0400, 1'b0}, {14'h0408, 1'b1},
		{14'h0440, 1'b0}, {14'h2000, 1'b0}, {14'h2040, 1'b1}, {14'h000F, 1'b1}};
	// channel enables beside the words per ten periods
	localparam logic [15:0] en_rows [6] = '{{8'h01, 8'h0A}, {8'hA5, 8'h28},
		{8'hFF, 8'h50}, {8'h80, 8'h0A}, {8'h00, 8'h00}, {8'h5A, 8'h28}};

	always #12.5 clk_i = ~clk_i;

	mbd_bank i_mbd_bank (.clk_i(clk_i), .rstn_i(rstn_i), .adc_i(adc_i), .src_sel_i(src_sel_i),
		.sync_i(sync_i), .gate_i(gate_i), .gate_bypass_i(gate_bypass_i), .dec_i(dec_i),
		.dec_load_i(dec_load_i), .tune_i(tune_i), .phase_i(phase_i), .ch_en_i(ch_en_i),
		.coef_we_i(coef_we_i), .coef_addr_i(coef_addr_i), .coef_data_i(coef_data_i),
		.coef_dflt_i(coef_dflt_i), .ovr_clr_i(ovr_clr_i), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i), .out_ch_o(out_ch_o), .out_i_o(out_i_o),
		.out_q_o(out_q_o), .dec_o(dec_o), .dec_err_o(dec_err_o), .ovr_o(ovr_o));

	mbd_sink i_mbd_sink (.clk_i(clk_i), .rstn_i(rstn_i), .stall_i(stall),
		.valid_i(out_valid_o), .ready_o(out_ready_i), .ch_i(out_ch_o), .i_i(out_i_o),
		.q_i(out_q_o));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// next enabled channel above c, wrapping; ascending scan order
	function automatic logic [2:0] nxt(input logic [7:0] en, input logic [2:0] c);
		logic [2:0] j;
		j = c;
		for (int k = 0; k < 8; k++)
		begin
			j = j + 3'h1;
			if (en[j])
				return j;
		end
		return c;
	endfunction

	task automatic load_dec(input logic [13:0] n);
		@(posedge clk_i);
		dec_i <= n;
		dec_load_i <= 1'b1;
		@(posedge clk_i);
		dec_load_i <= 1'b0;
		#1;
	endtask

	task automatic settle(input logic [1:0] s, input int n);
		@(posedge clk_i);
		sync_i <= s;
		@(posedge clk_i);
		sync_i <= 2'h0;
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// a window of whole periods always holds the same number of words
	task automatic measure(input int n, input logic [7:0] en, input logic [7:0] cnt);
		bit ok;
		ok = 1'b1;
		@(negedge clk_i);
		i_mbd_sink.ch_q.delete();
		repeat (n) @(negedge clk_i);
		for (int i = 1; i < i_mbd_sink.ch_q.size(); i++)
			if (i_mbd_sink.ch_q[i] !== nxt(en, i_mbd_sink.ch_q[i-1]))
				ok = 1'b0;
		check(i_mbd_sink.ch_q.size(), cnt);
		check(ok, 1'b1);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		for (int k = 0; k < 8; k++)
			tune_i[k] = {k[3:0], 28'h0000000};
		repeat (16) @(posedge clk_i);
		check({out_valid_o, dec_err_o, ovr_o, dec_o}, {3'h0, `MBD_DEC_RST});
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check(dec_o, `MBD_DEC_RST);
		for (int r = 0; r < 10; r++)
		begin
			load_dec(dec_rows[r][14:1]);
			check(dec_err_o, dec_rows[r][0]);
		end
		settle(2'h1, 3);
		check(dec_o, 14'h2000);
		load_dec(14'h0018);
		settle(2'h2, 3);
		check(dec_o, 14'h0018);
		@(posedge clk_i);
		ch_en_i <= 8'h0F;
		settle(2'h1, 72);
		measure(240, 8'h0F, 8'h28);
		load_dec(14'h0010);
		for (int r = 0; r < 6; r++)
		begin
			ch_en_i <= en_rows[r][15:8];
			settle(2'h1, 48);
			measure(160, en_rows[r][15:8], en_rows[r][7:0]);
		end
		gate_bypass_i <= 1'b0;
		ch_en_i <= 8'h0F;
		for (int g = 0; g < 4; g++)
		begin
			gate_i <= g[1:0];
			settle(2'h2, 48);
			measure(160, 8'h0F, (g == 0) ? 8'h00 : 8'h28);
		end
		// only the selected stream or the test ramp reaches the channels
		gate_bypass_i <= 1'b1;
		ch_en_i <= 8'h01;
		for (int s = 0; s < 5; s++)
		begin
			src_sel_i <= s[2:0];
			settle(2'h1, 64);
			check(i_mbd_sink.last_q[0] !== 48'h0, s == 2 || s == 4);
		end
		// back-to-back writes clear the window; a live source keeps the check honest
		src_sel_i <= 3'h2;
		for (int a = 0; a < 8; a++)
		begin
			@(posedge clk_i);
			coef_we_i <= 1'b1;
			coef_addr_i <= a[2:0];
		end
		@(posedge clk_i);
		coef_we_i <= 1'b0;
		settle(2'h1, 64);
		check(i_mbd_sink.last_q[0] !== 48'h0, 1'b0);
		coef_dflt_i <= 1'b1;
		@(posedge clk_i);
		coef_dflt_i <= 1'b0;
		settle(2'h1, 64);
		check(i_mbd_sink.last_q[0] !== 48'h0, 1'b1);
		// half-turn offset makes I negative and Q positive on a dc input
		phase_i[0] <= 32'h80000000;
		settle(2'h1, 64);
		check({i_mbd_sink.last_q[0][47], i_mbd_sink.last_q[0][23]}, 2'h2);
		// a long receiver stall overruns the scan, words are held meanwhile
		ch_en_i <= 8'hFF;
		stall <= 1'b1;
		settle(2'h1, 80);
		check({ovr_o, out_valid_o}, 2'h3);
		stall <= 1'b0;
		repeat (32) @(posedge clk_i);
		ovr_clr_i <= 1'b1;
		@(posedge clk_i);
		ovr_clr_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		check(ovr_o, 1'b0);
		measure(160, 8'hFF, 8'h50);
		finish_test();
	end

	// hang guard, well beyond the few thousand cycles the sequence needs
	initial
	begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		finish_test();
	end
endmodule
